// ===== design/csc_regs.sv
// Reset-cause, secondary interrupt enable and chip control registers behind AXI4-Lite.
// Assumes reset events, interrupt flags and sequencer state come from logic on aclk;
// only the brown-out comparator level is asynchronous and is synchronised here.
// How it works
// - Enable bit 2 gates wake timer request.
// - Enable bit 1 gates timer 3 request.
// - Enable bit 0 gates serial port 1 requests.
// - Cause bit 5 shares hard-fault flag; zero clears.
// - Cause bit 4 shares power-on flag; zero clears.
// - Cause bit 3 shares reset-pin flag; zero clears.
// - Cause bit 2 shares brown-out flag; zero clears.
// - Cause bit 1 shares watchdog flag; zero clears.
// - Cause bit 0 shares software flag; zero clears.
// - Chip control writes need timed access open.
// - Bad address, command or block sets fault.
// - Programming under unguarded brown-out sets fault.
// - Program enable turns on fast oscillator.
// - Boot select chooses loader or main area.
`timescale 1ns/1ps
module csc_regs
  import csc_pkg::*;
#(
  parameter logic [15:0] FLASH_SIZE = FLASH_BYTES
)(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  boot_select_strap,
  input  wire logic                  timed_access_protection,
  input  wire csc_pkg::csc_rst_evt_s reset_event,
  input  wire csc_pkg::csc_irq_src_s irq_source,
  input  wire csc_pkg::csc_prog_s    program_state,
  input  wire logic                  brownout_below_level,
  output logic                       wake_timer_irq,
  output logic                       timer3_irq,
  output logic                       serial_port1_irq,
  output logic                       internal_fast_oscillator_on,
  output logic                       boot_from_loader,
  output logic                       irq
);

  // ****************************************************************
  // State of the module.
  // ****************************************************************
  typedef struct packed {
    logic        aw_held;
    logic        w_held;
    logic [9:0]  waddr;
    logic [7:0]  wdata;
    logic        wlane;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [2:0]  irq_enable;
    logic [5:0]  cause;
    logic        fault;
    logic        boot_sel;
    logic        pgm_en;
    logic [1:0]  evt_status;
    logic [1:0]  evt_mask;
    logic        bod_meta;
    logic        bod_level;
    logic        wake_irq;
    logic        t3_irq;
    logic        s1_irq;
    logic        osc_on;
    logic        boot_loader;
    logic        irq;
  } csc_state_s;

  csc_state_s st;
  csc_state_s next_st;

  // ****************************************************************
  // Address decoding, shared by reads and writes.
  // ****************************************************************
  function automatic csc_sel_e decode(input logic [9:0] word);
    csc_sel_e sel;
    sel = SEL_NONE;
    if (word[9:8] != 2'h0)
      sel = SEL_NONE;
    else if (word[7:0] == IDX_IRQ_ENABLE2)
      sel = SEL_IE;
    else if (word[7:0] == IDX_RESET_CAUSE)
      sel = SEL_RC;
    else if (word[7:0] == IDX_CHIP_CTRL)
      sel = SEL_CC;
    else if (word[7:0] == IDX_AUX_FLAGS)
      sel = SEL_AUX;
    else if (word[7:0] == IDX_BOD_CTRL)
      sel = SEL_BOD;
    else if (word[7:0] == IDX_PWR_CTRL)
      sel = SEL_PWR;
    else if (word[7:0] == IDX_WDOG_CTRL)
      sel = SEL_WDG;
    else if (word[7:0] == IDX_EVT_STATUS)
      sel = SEL_STS;
    else if (word[7:0] == IDX_EVT_MASK)
      sel = SEL_MSK;
    return sel;
  endfunction : decode

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb
  begin
    csc_sel_e   wsel;
    csc_sel_e   rsel;
    logic       do_write;
    logic [7:0] rbyte;
    logic [5:0] keep;
    logic       cc_write;
    logic       fault_evt;
    logic       refused_evt;
    next_st     = st;
    wsel        = SEL_NONE;
    rsel        = SEL_NONE;
    do_write    = 1'b0;
    rbyte       = 8'h00;
    keep        = 6'h3f;
    cc_write    = 1'b0;
    fault_evt   = 1'b0;
    refused_evt = 1'b0;

    // Capture write address and data, in either order.
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.waddr   = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata[7:0];
      next_st.wlane  = s_axi_wstrb[0];
    end
    do_write = st.aw_held && st.w_held && !st.bvalid;
    if (do_write)
    begin
      wsel            = decode(st.waddr);
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    // Register writes; only byte lane 0 carries the 8-bit registers.
    if (do_write && st.wlane)
    begin
      if (wsel == SEL_IE)
        next_st.irq_enable = st.wdata[2:0] & IE_MASK;
      else if (wsel == SEL_RC)
        keep = st.wdata[5:0];
      else if (wsel == SEL_AUX)
      begin
        keep[RC_SOFT] = st.wdata[AUX_SOFT];
        keep[RC_PIN]  = st.wdata[AUX_PIN];
        keep[RC_HARD] = st.wdata[AUX_HARD];
      end
      else if (wsel == SEL_PWR)
        keep[RC_POWER] = st.wdata[PWR_POWER];
      else if (wsel == SEL_BOD)
        keep[RC_BROWN] = st.wdata[BOD_BROWN];
      else if (wsel == SEL_WDG)
        keep[RC_WDOG] = st.wdata[WDG_WDOG];
      else if (wsel == SEL_CC)
      begin
        cc_write    = timed_access_protection;
        refused_evt = !timed_access_protection;
      end
      else if (wsel == SEL_MSK)
        next_st.evt_mask = st.wdata[1:0];
    end

    // Shared reset flags: a reported cause wins over a clearing write.
    next_st.cause = st.cause & keep;
    if (reset_event.hard_fault)
      next_st.cause[RC_HARD] = 1'b1;
    if (reset_event.reset_pin)
      next_st.cause[RC_PIN] = 1'b1;
    if (reset_event.brownout)
      next_st.cause[RC_BROWN] = 1'b1;
    if (reset_event.watchdog)
      next_st.cause[RC_WDOG] = 1'b1;
    if (reset_event.software)
      next_st.cause[RC_SOFT] = 1'b1;

    // Chip control: protected fields written only while access is open.
    if (cc_write)
    begin
      next_st.fault    = st.wdata[CC_FAULT];
      next_st.boot_sel = st.wdata[CC_BOOT];
      next_st.pgm_en   = st.wdata[CC_PGM_EN];
    end

    // Programming fault detection; the hardware only ever sets the flag.
    if (program_state.program_trigger &&
        (program_state.address >= FLASH_SIZE || !program_state.command_valid ||
         (program_state.erase_or_write && !program_state.block_enabled)))
      fault_evt = 1'b1;
    if (program_state.active && program_state.erase_or_write && st.bod_level &&
        program_state.brownout_detect_enable && !program_state.brownout_reset_enable &&
        program_state.program_under_brownout_cfg)
      fault_evt = 1'b1;
    if (fault_evt)
      next_st.fault = 1'b1;

    // Brown-out comparator synchroniser.
    next_st.bod_meta  = brownout_below_level;
    next_st.bod_level = st.bod_meta;

    // Event status: write one to clear, a new event wins.
    if (do_write && st.wlane && wsel == SEL_STS)
      next_st.evt_status = st.evt_status & ~st.wdata[1:0];
    if (fault_evt && !st.fault)
      next_st.evt_status[EV_FAULT] = 1'b1;
    if (refused_evt)
      next_st.evt_status[EV_REFUSED] = 1'b1;

    // Read channel: one read in flight, answered the cycle after acceptance.
    if (s_axi_arvalid && st.arready)
    begin
      rsel = decode(s_axi_araddr[11:2]);
      if (rsel == SEL_IE)
        rbyte = {5'h00, st.irq_enable};
      else if (rsel == SEL_RC)
        rbyte = {2'h0, st.cause};
      else if (rsel == SEL_CC)
        rbyte = {1'b0, st.fault, 4'h0, st.boot_sel, st.pgm_en};
      else if (rsel == SEL_AUX)
        rbyte = {st.cause[RC_SOFT], st.cause[RC_PIN], st.cause[RC_HARD], 5'h00};
      else if (rsel == SEL_PWR)
        rbyte = {3'h0, st.cause[RC_POWER], 4'h0};
      else if (rsel == SEL_BOD)
        rbyte = {6'h00, st.cause[RC_BROWN], 1'b0};
      else if (rsel == SEL_WDG)
        rbyte = {4'h0, st.cause[RC_WDOG], 3'h0};
      else if (rsel == SEL_STS)
        rbyte = {6'h00, st.evt_status};
      else if (rsel == SEL_MSK)
        rbyte = {6'h00, st.evt_mask};
      next_st.rvalid = 1'b1;
      next_st.rdata  = {24'h000000, rbyte};
      next_st.rresp  = (rsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    else if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;

    // Ready flags registered so that every bus output leaves a flip-flop.
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;

    // Gated requests and derived outputs, one cycle behind their causes.
    next_st.wake_irq    = st.irq_enable[IE_WAKE] & irq_source.wake_timer_overflow_flag;
    next_st.t3_irq      = st.irq_enable[IE_TIMER3] & irq_source.timer3_overflow_flag;
    next_st.s1_irq      = st.irq_enable[IE_SERIAL1] &
                          (irq_source.serial1_transmit_done | irq_source.serial1_receive_done);
    next_st.osc_on      = st.pgm_en;
    next_st.boot_loader = st.boot_sel;
    next_st.irq         = |(st.evt_status & st.evt_mask);

    // Power-on reset; the boot strap is sampled at this synchronous reset.
    if (!aresetn)
    begin
      next_st             = '0;
      next_st.cause       = RC_POR_VALUE;
      next_st.boot_sel    = boot_select_strap;
      next_st.boot_loader = boot_select_strap;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  // Outputs taken straight from the state register.
  assign s_axi_awready               = st.awready;
  assign s_axi_wready                = st.wready;
  assign s_axi_bvalid                = st.bvalid;
  assign s_axi_bresp                 = st.bresp;
  assign s_axi_arready               = st.arready;
  assign s_axi_rvalid                = st.rvalid;
  assign s_axi_rdata                 = st.rdata;
  assign s_axi_rresp                 = st.rresp;
  assign wake_timer_irq              = st.wake_irq;
  assign timer3_irq                  = st.t3_irq;
  assign serial_port1_irq            = st.s1_irq;
  assign internal_fast_oscillator_on = st.osc_on;
  assign boot_from_loader            = st.boot_loader;
  assign irq                         = st.irq;

endmodule : csc_regs

// ===== design/csc_pkg.sv
// Constants and carrier types for the reset-cause and chip-control register group.
// Assumes a single 25 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package csc_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] IDX_IRQ_ENABLE2 = 8'h9c;
  localparam logic [7:0] IDX_RESET_CAUSE = 8'h9d;
  localparam logic [7:0] IDX_CHIP_CTRL   = 8'h9f;
  localparam logic [7:0] IDX_AUX_FLAGS   = 8'ha2;
  localparam logic [7:0] IDX_BOD_CTRL    = 8'ha3;
  localparam logic [7:0] IDX_PWR_CTRL    = 8'hb0;
  localparam logic [7:0] IDX_WDOG_CTRL   = 8'hb1;
  localparam logic [7:0] IDX_EVT_STATUS  = 8'hb2;
  localparam logic [7:0] IDX_EVT_MASK    = 8'hb3;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int IE_WAKE    = 2;
  localparam int IE_TIMER3  = 1;
  localparam int IE_SERIAL1 = 0;
  localparam int RC_HARD    = 5;
  localparam int RC_POWER   = 4;
  localparam int RC_PIN     = 3;
  localparam int RC_BROWN   = 2;
  localparam int RC_WDOG    = 1;
  localparam int RC_SOFT    = 0;
  localparam int AUX_SOFT   = 7;
  localparam int AUX_PIN    = 6;
  localparam int AUX_HARD   = 5;
  localparam int PWR_POWER  = 4;
  localparam int BOD_BROWN  = 1;
  localparam int WDG_WDOG   = 3;
  localparam int CC_FAULT   = 6;
  localparam int CC_BOOT    = 1;
  localparam int CC_PGM_EN  = 0;
  localparam int EV_FAULT   = 0;
  localparam int EV_REFUSED = 1;

  // ****************************************************************
  // Write mask, reset value, bus answers and flash size.
  // ****************************************************************
  localparam logic [2:0] IE_MASK      = 3'h7;
  localparam logic [5:0] RC_POR_VALUE = 6'h10;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;
  localparam logic [15:0] FLASH_BYTES = 16'h4000;

  // Register selected by a decoded address.
  typedef enum logic [9:0] {
    SEL_NONE = 10'h001, SEL_IE = 10'h002, SEL_RC = 10'h004, SEL_CC = 10'h008, SEL_AUX = 10'h010,
    SEL_BOD  = 10'h020, SEL_PWR = 10'h040, SEL_WDG = 10'h080, SEL_STS = 10'h100, SEL_MSK = 10'h200
  } csc_sel_e;

  // Reset causes reported by the reset controller, one-cycle pulses.
  typedef struct packed {
    logic hard_fault;
    logic brownout;
    logic reset_pin;
    logic watchdog;
    logic software;
  } csc_rst_evt_s;

  // Interrupt flags of the peripherals gated here.
  typedef struct packed {
    logic wake_timer_overflow_flag;
    logic timer3_overflow_flag;
    logic serial1_transmit_done;
    logic serial1_receive_done;
  } csc_irq_src_s;

  // State of the flash programming sequencer.
  typedef struct packed {
    logic        program_trigger;
    logic [15:0] address;
    logic        command_valid;
    logic        erase_or_write;
    logic        block_enabled;
    logic        active;
    logic        brownout_detect_enable;
    logic        brownout_reset_enable;
    logic        program_under_brownout_cfg;
  } csc_prog_s;

endpackage : csc_pkg

// ===== testbench/csc_regs_props.sv
// Concurrent checks on the ports of the reset-cause and chip-control register group.
// Assumes one clock aclk and the synchronous active-low reset aresetn.
`timescale 1ns/1ps
module csc_regs_props
  import csc_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  boot_select_strap,
  input wire logic                  timed_access_protection,
  input wire csc_pkg::csc_irq_src_s irq_source,
  input wire logic                  wake_timer_irq,
  input wire logic                  timer3_irq,
  input wire logic                  serial_port1_irq,
  input wire logic                  internal_fast_oscillator_on,
  input wire logic                  boot_from_loader
);
  // ****************************************************************
  // Checks, all in the aclk domain.
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A gated request never appears without its source flag one edge earlier.
  chk_wake_gate: assert property (
    wake_timer_irq |-> $past(irq_source.wake_timer_overflow_flag)) else $error("wake request without flag");
  chk_timer3_gate: assert property (
    timer3_irq |-> $past(irq_source.timer3_overflow_flag)) else $error("timer3 request without flag");
  chk_serial_gate: assert property (
    serial_port1_irq |-> $past(irq_source.serial1_transmit_done || irq_source.serial1_receive_done))
    else $error("serial request without flag");
  // Boot output shows the strap right after reset.
  chk_boot_strap: assert property (
    $past(!aresetn) |-> boot_from_loader == $past(boot_select_strap)) else $error("boot output not strap");
  // Chip control outputs change only after an accepted protected write.
  chk_osc_written: assert property (
    !$stable(internal_fast_oscillator_on) |-> $past(s_axi_bvalid) && $past(timed_access_protection))
    else $error("oscillator changed without protected write");
  chk_boot_written: assert property (
    !$stable(boot_from_loader) |-> $past(s_axi_bvalid) && $past(timed_access_protection))
    else $error("boot select changed without protected write");
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits not zero");
  // Bus answer timing as handed over.
  chk_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  chk_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule : csc_regs_props

bind csc_regs csc_regs_props csc_regs_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .boot_select_strap, .timed_access_protection, .irq_source, .wake_timer_irq,
  .timer3_irq, .serial_port1_irq, .internal_fast_oscillator_on, .boot_from_loader);

// ===== testbench/tb_csc_regs.sv
// Self-checking bench for the register group, driven over AXI4-Lite.
// Assumes the checker is bound from its own file; flash size is shrunk.
`timescale 1ns/1ps
module tb_csc_regs;
  import csc_pkg::*;
  localparam logic [15:0] FSZ = 16'h0800;
  localparam logic [7:0] MIDX [6] = '{IDX_AUX_FLAGS, IDX_WDOG_CTRL, IDX_AUX_FLAGS, IDX_BOD_CTRL, IDX_AUX_FLAGS,
                                      IDX_PWR_CTRL};
  localparam int MBIT [6] = '{AUX_SOFT, WDG_WDOG, AUX_PIN, BOD_BROWN, AUX_HARD, PWR_POWER};
  localparam int RBIT [6] = '{RC_SOFT, RC_WDOG, RC_PIN, RC_BROWN, RC_HARD, RC_POWER};
  logic         aclk = 1'b0, aresetn = 1'b0;
  logic [11:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]  s_axi_wdata = '0, s_axi_rdata, v;
  logic [3:0]   s_axi_wstrb = 4'h1;
  logic         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic         wake_timer_irq, timer3_irq, serial_port1_irq, internal_fast_oscillator_on, boot_from_loader;
  logic [1:0]   s_axi_bresp, s_axi_rresp, r;
  logic         boot_select_strap = 1, timed_access_protection = 0, brownout_below_level = 0;
  csc_rst_evt_s reset_event = '0;
  csc_irq_src_s irq_source = '0;
  csc_prog_s    program_state = '0, ps;
  int           n_fail = 0, cmp_count = 0;

  // Free-running 25 MHz clock.
  always #20 aclk = ~aclk;

  csc_regs #(.FLASH_SIZE(FSZ)) csc_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .boot_select_strap, .timed_access_protection, .reset_event, .irq_source, .program_state,
    .brownout_below_level, .wake_timer_irq, .timer3_irq, .serial_port1_irq, .internal_fast_oscillator_on,
    .boot_from_loader, .irq);

  // ****************************************************************
  // Bus tasks and comparison.
  // ****************************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic give_up();
    n_fail++;
    tally_and_finish();
  endtask : give_up

  // Write one byte; address and data are offered together and dropped when taken.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (n == 50) give_up();
  endtask : wr

  // Read one word into v and its response into r.
  task automatic rd(input logic [7:0] idx);
    int n;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (n == 50) give_up();
  endtask : rd

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IDX_RESET_CAUSE); chk(v, 32'h10);
    rd(IDX_CHIP_CTRL); chk(v, 32'h02);
    chk(32'(boot_from_loader), 1);
    rd(8'h10); chk(32'(r), 32'(RESP_DECERR));
    wr(IDX_IRQ_ENABLE2, 8'hff); rd(IDX_IRQ_ENABLE2); chk(v, 32'h7);
    // A write without byte lane 0 is answered but ignored; an unmapped write is refused.
    s_axi_wstrb <= 4'h0;
    wr(IDX_IRQ_ENABLE2, 8'h00);
    chk(32'(r), 32'(RESP_OKAY));
    s_axi_wstrb <= 4'h1;
    rd(IDX_IRQ_ENABLE2); chk(v, 32'h7);
    wr(8'h10, 8'h00);
    chk(32'(r), 32'(RESP_DECERR));
    // Each source alone with all enables on, then every enable pattern.
    for (int s = 0; s < 4; s++)
    begin
      irq_source <= 4'(1 << s);
      repeat (3) @(posedge aclk);
      chk({29'h0, wake_timer_irq, timer3_irq, serial_port1_irq}, s == 3 ? 4 : s == 2 ? 2 : 1);
    end
    irq_source <= 4'hf;
    for (int b = 0; b < 8; b++)
    begin
      wr(IDX_IRQ_ENABLE2, 8'(b));
      repeat (3) @(posedge aclk);
      chk({29'h0, wake_timer_irq, timer3_irq, serial_port1_irq}, b);
    end
    // Each cause sets both copies; a zero in either copy clears both.
    for (int i = 0; i < 6; i++)
    begin
      if (i < 5)
      begin
        reset_event <= 5'(1 << i);
        @(posedge aclk);
        reset_event <= '0;
      end
      rd(IDX_RESET_CAUSE); chk(32'(v[RBIT[i]]), 1);
      rd(MIDX[i]); chk(32'(v[MBIT[i]]), 1);
      if (i % 2 == 1) wr(IDX_RESET_CAUSE, ~(8'h1 << RBIT[i]));
      else wr(MIDX[i], v[7:0] & ~(8'h1 << MBIT[i]));
      rd(IDX_RESET_CAUSE); chk(32'(v[RBIT[i]]), 0);
      rd(MIDX[i]); chk(32'(v[MBIT[i]]), 0);
    end
    // Unprotected write is refused and flagged as an event.
    wr(IDX_CHIP_CTRL, 8'h01); rd(IDX_CHIP_CTRL); chk(v, 32'h02);
    chk(32'(internal_fast_oscillator_on), 0);
    rd(IDX_EVT_STATUS); chk(v, 32'h2);
    chk(32'(irq), 0);
    wr(IDX_EVT_MASK, 8'h02); repeat (2) @(posedge aclk); chk(32'(irq), 1);
    wr(IDX_EVT_STATUS, 8'h02); repeat (2) @(posedge aclk); chk(32'(irq), 0);
    timed_access_protection <= 1'b1;
    wr(IDX_CHIP_CTRL, 8'h01); repeat (2) @(posedge aclk);
    chk(32'(internal_fast_oscillator_on), 1);
    chk(32'(boot_from_loader), 0);
    // Fault causes: oversize address, bad command, locked block, good op, brown-out.
    for (int k = 0; k < 5; k++)
    begin
      ps = '0;
      ps.program_trigger = (k != 4);
      ps.address = (k == 0) ? FSZ : FSZ - 16'h1;
      ps.command_valid = (k != 1);
      ps.erase_or_write = (k >= 2);
      ps.block_enabled = (k != 2);
      ps.active = (k == 4);
      ps.brownout_detect_enable = (k == 4);
      ps.program_under_brownout_cfg = (k == 4);
      program_state <= ps;
      brownout_below_level <= (k == 4);
      repeat (6) @(posedge aclk);
      program_state <= '0;
      brownout_below_level <= 1'b0;
      repeat (20) @(posedge aclk);
      rd(IDX_CHIP_CTRL); chk(v, k == 3 ? 32'h01 : 32'h41);
      wr(IDX_CHIP_CTRL, 8'h01);
    end
    // Each raised fault left its sticky event bit; the refused bit was cleared earlier.
    rd(IDX_EVT_STATUS); chk(v, 32'h1);
    wr(IDX_CHIP_CTRL, 8'h00); repeat (2) @(posedge aclk);
    chk(32'(internal_fast_oscillator_on), 0);
    // Second power-on reset in mid-run.
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IDX_RESET_CAUSE); chk(v, 32'h10);
    rd(IDX_IRQ_ENABLE2); chk(v, 32'h0);
    // Boot select was written to zero before the reset and must reload from the strap.
    rd(IDX_CHIP_CTRL); chk(v, 32'h02);
    chk(32'(boot_from_loader), 1);
    tally_and_finish();
  end
endmodule : tb_csc_regs
